//--- core/tx_cfg_defines.vh
/*
 constants for the transmit configuration and fifo allocation register bank.
 assumes inclusion by bare name from the design files under core/.
*/
// What this block does
// [R01] status flush bit clears status fifo pointers
// [R02] data flush bit clears data fifo pointers
// [R03] overrun allow bit decides pause on full
// [R04] status full interrupt independent of allow bit
// [R05] transmit enable lets waiting data send
// [R06] enable clears itself after stop completes
// [R07] stop finishes frame, then self clears
// [R08] stop bit ignores writes while set
// [R09] host stops tx and rx before config write
// [R10] host writes must be one bit as one
// [R11] tx fifo size field in 1KB steps, reset 5
// [R12] status fifo fixed 512 bytes, data gets rest
// [R13] host keeps tx size at least 2KB
// [R14] receive side gets 16KB minus tx space
// [R15] reserved bits read zero, ignore writes
`ifndef TX_CFG_DEFINES_VH
`define TX_CFG_DEFINES_VH
`define OFF_TRANSMIT_CONFIG 8'h70
`define OFF_HARDWARE_CONFIG 8'h74
`define OFF_IRQ_STATUS 8'h78
`define OFF_IRQ_CLEAR 8'h7c
`define OFF_IRQ_ENABLE 8'h80
`define OFF_TX_STATE 8'h84
`define BIT_TX_STATUS_FLUSH 15
`define BIT_TX_DATA_FLUSH 14
`define BIT_STATUS_OVERRUN_ALLOW 2
`define BIT_TX_ENABLE 1
`define BIT_STOP_REQUEST 0
`define BIT_MUST_BE_ONE 20
`define FIFO_SIZE_LSB 16
`define FIFO_SIZE_MSB 19
`define FIFO_SIZE_RESET 4'h5
`define FIFO_SIZE_MAX 4'he
`define TOTAL_BUFFER_BYTES 15'h4000
`define STATUS_FIFO_BYTES 15'h0200
`define KB_BYTES 15'h0400
`define IRQ_STATUS_FULL 0
`define IRQ_TX_STOPPED 1
`define IRQ_WIDTH 2
`endif

//--- core/tx_config_fifo_alloc.v
/*
 transmit configuration and hardware configuration registers behind an ahb-lite slave.
 assumes a transmitter that reports frame activity and status fifo fill on clk.
*/
`timescale 1ns/10ps
`include "tx_cfg_defines.vh"
module tx_config_fifo_alloc
(
	input wire clk,
	input wire rst_n,
	input wire hsel,
	input wire [31:0] haddr,
	input wire [1:0] htrans,
	input wire hwrite,
	input wire [2:0] hsize,
	input wire [31:0] hwdata,
	input wire hready,
	output reg [31:0] hrdata,
	output wire hreadyout,
	output wire hresp,
	input wire frame_active,
	input wire status_fifo_full,
	output wire tx_send_enable,
	output reg tx_status_ptr_clear,
	output reg tx_data_ptr_clear,
	output wire [14:0] tx_status_bytes,
	output wire [14:0] tx_data_bytes,
	output wire [14:0] rx_bytes,
	output wire must_be_one_bit,
	output wire irq
);
	// transmitter control states, one-hot
	localparam ST_OFF = 3'b001;
	localparam ST_RUN = 3'b010;
	localparam ST_STOPPING = 3'b100;

	reg [2:0] state;
	reg [2:0] next_state;
	reg tx_enable;
	reg stop_request;
	reg status_overrun_allow;
	reg must_be_one;
	reg [3:0] tx_fifo_size_kb;
	reg [`IRQ_WIDTH-1:0] irq_status;
	reg [`IRQ_WIDTH-1:0] irq_enable;
	reg full_d;
	reg wr_pend;
	reg [7:0] wr_addr;
	wire [14:0] tx_total_bytes;
	wire addr_phase;
	wire wr_data;
	wire wr_tc;
	wire wr_hc;
	wire wr_clr;
	wire wr_en;
	wire halted;
	wire [`IRQ_WIDTH-1:0] irq_event;
	reg [31:0] tc_read;
	reg [31:0] hc_read;

	assign hreadyout = 1'b1;
	assign hresp = 1'b0;
	assign addr_phase = hsel && hready && htrans[1];

	// writes land in the data phase; reads answer in the data phase from flops
	always @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			wr_pend <= 1'b0;
			wr_addr <= 8'h00;
		end
		else if (hready)
		begin
			wr_pend <= addr_phase && hwrite;
			wr_addr <= haddr[7:0];
		end
	end

	assign wr_data = wr_pend;
	assign wr_tc = wr_data && (wr_addr == `OFF_TRANSMIT_CONFIG);
	assign wr_hc = wr_data && (wr_addr == `OFF_HARDWARE_CONFIG);
	assign wr_clr = wr_data && (wr_addr == `OFF_IRQ_CLEAR);
	assign wr_en = wr_data && (wr_addr == `OFF_IRQ_ENABLE);

	// stop done once the frame in flight has ended
	assign halted = (state == ST_STOPPING) && !frame_active; // [R07]

	always @*
	begin
		next_state = state;
		case (state)
			ST_OFF:
				if (tx_enable)
					next_state = ST_RUN;
			ST_RUN:
				if (stop_request)
					next_state = ST_STOPPING;
				else if (!tx_enable)
					next_state = ST_OFF;
			ST_STOPPING:
				if (!frame_active)
					next_state = ST_OFF; // [R07]
			default:
				next_state = ST_OFF;
		endcase
	end

	always @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			state <= ST_OFF;
			tx_enable <= 1'b0;
			stop_request <= 1'b0;
			status_overrun_allow <= 1'b0;
			tx_status_ptr_clear <= 1'b0;
			tx_data_ptr_clear <= 1'b0;
		end
		else
		begin
			state <= next_state;
			// flush bits never hold: one pulse per written one
			tx_status_ptr_clear <= wr_tc && hwdata[`BIT_TX_STATUS_FLUSH]; // [R01]
			tx_data_ptr_clear <= wr_tc && hwdata[`BIT_TX_DATA_FLUSH]; // [R02]
			if (wr_tc)
				status_overrun_allow <= hwdata[`BIT_STATUS_OVERRUN_ALLOW];
			// halting wins over a same-cycle host write of the enable
			if (halted)
				tx_enable <= 1'b0; // [R06]
			else if (wr_tc)
				tx_enable <= hwdata[`BIT_TX_ENABLE];
			if (halted)
				stop_request <= 1'b0; // [R07]
			else if (wr_tc && !stop_request && hwdata[`BIT_STOP_REQUEST]) // [R08]
				stop_request <= 1'b1;
			else if (stop_request && state == ST_OFF)
				stop_request <= 1'b0; // [R07]
		end
	end

	// stopping keeps sending until the current frame ends
	assign tx_send_enable = (tx_enable || state == ST_STOPPING) &&
		!(status_fifo_full && !status_overrun_allow) &&
		!(state == ST_STOPPING && !frame_active); // [R03] [R05]

	always @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			must_be_one <= 1'b0;
			tx_fifo_size_kb <= `FIFO_SIZE_RESET;
		end
		else if (wr_hc)
		begin
			must_be_one <= hwdata[`BIT_MUST_BE_ONE]; // [R10]
			// values above the 14KB ceiling are clamped to it
			if (hwdata[`FIFO_SIZE_MSB:`FIFO_SIZE_LSB] > `FIFO_SIZE_MAX)
				tx_fifo_size_kb <= `FIFO_SIZE_MAX; // [R11]
			else
				tx_fifo_size_kb <= hwdata[`FIFO_SIZE_MSB:`FIFO_SIZE_LSB]; // [R11]
		end
	end
	assign must_be_one_bit = must_be_one;

	tx_fifo_alloc u_alloc
	(
		.tx_fifo_size_kb(tx_fifo_size_kb),
		.tx_total_bytes(tx_total_bytes),
		.tx_status_bytes(tx_status_bytes),
		.tx_data_bytes(tx_data_bytes),
		.rx_bytes(rx_bytes)
	);

	// interrupt: rising edge of status full, regardless of overrun allow
	always @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			full_d <= 1'b0;
		else
			full_d <= status_fifo_full;
	end
	assign irq_event[`IRQ_STATUS_FULL] = status_fifo_full && !full_d; // [R04]
	assign irq_event[`IRQ_TX_STOPPED] = halted;

	genvar i;
	generate
		for (i = 0; i < `IRQ_WIDTH; i = i + 1)
		begin : g_irq
			// a new event beats a clear in the same cycle
			always @(posedge clk or negedge rst_n)
			begin
				if (!rst_n)
					irq_status[i] <= 1'b0;
				else if (irq_event[i])
					irq_status[i] <= 1'b1;
				else if (wr_clr && hwdata[i])
					irq_status[i] <= 1'b0;
			end
		end
	endgenerate

	always @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			irq_enable <= {`IRQ_WIDTH{1'b0}};
		else if (wr_en)
			irq_enable <= hwdata[`IRQ_WIDTH-1:0];
	end
	assign irq = |(irq_status & irq_enable);

	// reserved positions stay zero; flush bits always read zero
	always @*
	begin
		tc_read = 32'h00000000;
		tc_read[`BIT_STATUS_OVERRUN_ALLOW] = status_overrun_allow; // [R15]
		tc_read[`BIT_TX_ENABLE] = tx_enable;
		tc_read[`BIT_STOP_REQUEST] = stop_request;
		hc_read = 32'h00000000;
		hc_read[`BIT_MUST_BE_ONE] = must_be_one; // [R15]
		hc_read[`FIFO_SIZE_MSB:`FIFO_SIZE_LSB] = tx_fifo_size_kb;
	end

	always @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			hrdata <= 32'h00000000;
		else if (addr_phase && !hwrite)
		begin
			case (haddr[7:0])
				`OFF_TRANSMIT_CONFIG: hrdata <= tc_read;
				`OFF_HARDWARE_CONFIG: hrdata <= hc_read;
				`OFF_IRQ_STATUS: hrdata <= {30'h00000000, irq_status};
				`OFF_IRQ_ENABLE: hrdata <= {30'h00000000, irq_enable};
				`OFF_TX_STATE: hrdata <= {29'h00000000, state};
				default: hrdata <= 32'h00000000;
			endcase
		end
	end
endmodule

//--- core/tx_fifo_alloc.v
/*
 splits the shared 16KB buffer between transmit status, transmit data and receive.
 assumes a size field already capped at 14KB by the caller; the 2KB floor is left to the host.
*/
`timescale 1ns/10ps
`include "tx_cfg_defines.vh"
module tx_fifo_alloc
(
	input wire [3:0] tx_fifo_size_kb,
	output wire [14:0] tx_total_bytes,
	output wire [14:0] tx_status_bytes,
	output wire [14:0] tx_data_bytes,
	output wire [14:0] rx_bytes
);
	wire [18:0] scaled;
	assign scaled = {4'h0, `KB_BYTES} * {15'h0000, tx_fifo_size_kb};
	assign tx_total_bytes = scaled[14:0]; // [R11]
	assign tx_status_bytes = `STATUS_FIFO_BYTES; // [R12]
	// below 2KB the host broke its side; the data share must not wrap
	assign tx_data_bytes = (tx_total_bytes > `STATUS_FIFO_BYTES) ?
		(tx_total_bytes - `STATUS_FIFO_BYTES) : 15'h0000; // [R12]
	assign rx_bytes = `TOTAL_BUFFER_BYTES - tx_total_bytes; // [R14]
endmodule

//--- testbench/tb_top.sv
/*
 register level bench for the transmit configuration bank.
 assumes a zero wait ahb-lite slave; the bench is the only master.
*/
`timescale 1ns/10ps
module tb_top;
	reg clk = 0;
	reg rst_n = 0;
	reg hsel = 0;
	reg hwrite = 0;
	reg frame_active = 0;
	reg status_fifo_full = 0;
	reg [1:0] htrans = 0;
	reg [31:0] haddr = 0;
	reg [31:0] hwdata = 0;
	reg [31:0] r;
	wire [31:0] hrdata;
	wire hreadyout, hresp, tx_send_enable, tx_status_ptr_clear, tx_data_ptr_clear, must_be_one_bit, irq;
	wire [14:0] tx_status_bytes, tx_data_bytes, rx_bytes;
	integer num_errors = 0;
	integer n_compared = 0;
	always #4 clk = ~clk;
	tx_config_fifo_alloc tx_config_fifo_alloc_inst (.clk(clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
		.hreadyout(hreadyout), .hresp(hresp), .frame_active(frame_active), .status_fifo_full(status_fifo_full),
		.tx_send_enable(tx_send_enable), .tx_status_ptr_clear(tx_status_ptr_clear),
		.tx_data_ptr_clear(tx_data_ptr_clear), .tx_status_bytes(tx_status_bytes), .tx_data_bytes(tx_data_bytes),
		.rx_bytes(rx_bytes), .must_be_one_bit(must_be_one_bit), .irq(irq));
	task summarize;
	begin
		$display("compared %0d mismatched %0d", n_compared, num_errors);
		if (num_errors == 0 && n_compared > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	end
	endtask
	task chk(input string n, input [31:0] e, input [31:0] g);
	begin
		n_compared = n_compared + 1;
		if (g !== e)
		begin
			num_errors = num_errors + 1;
			$display("[ERR] %s expected %h seen %h", n, e, g);
		end
	end
	endtask
	// one single transfer; waits on hready in both phases
	task xf(input w, input [7:0] a, input [31:0] d);
	begin
		@(posedge clk);
		hsel <= 1'b1;
		haddr <= {24'h0, a};
		hwrite <= w;
		htrans <= 2'h2;
		@(posedge clk);
		while (hreadyout !== 1'b1) @(posedge clk);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		@(posedge clk);
		while (hreadyout !== 1'b1) @(posedge clk);
		r = hrdata;
	end
	endtask
	task rd(input [7:0] a, input [31:0] e, input string n);
	begin
		xf(1'b0, a, 32'h0);
		chk(n, e, r);
	end
	endtask
	// write lands at the data edge, state follows one edge later
	task wt;
	begin
		repeat (2) @(posedge clk);
		#1;
	end
	endtask
	initial
	begin
		repeat (12) @(posedge clk);
		rst_n <= 1'b1;
		rd(8'h70, 32'h0, "txcfg reset");
		rd(8'h74, 32'h00050000, "hwcfg reset");
		chk("data bytes", 32'd4608, {17'h0, tx_data_bytes});
		rd(8'h90, 32'h0, "unmapped");
		xf(1'b1, 8'h74, 32'hffffffff);
		rd(8'h74, 32'h001e0000, "hwcfg clamp");
		chk("rx bytes", 32'd2048, {17'h0, rx_bytes});
		chk("mbo", 32'h1, {31'h0, must_be_one_bit});
		xf(1'b1, 8'h74, 32'h00120000);
		// the write lands on the edge that xf returns at; let it settle
		#1;
		chk("data bytes", 32'd1536, {17'h0, tx_data_bytes});
		chk("rx bytes", 32'd14336, {17'h0, rx_bytes});
		$display("test 1 done");
		xf(1'b1, 8'h80, 32'h3);
		xf(1'b1, 8'h70, 32'h2);
		wt;
		chk("send on", 32'h1, {31'h0, tx_send_enable});
		@(posedge clk) status_fifo_full <= 1'b1;
		wt;
		chk("send full", 32'h0, {31'h0, tx_send_enable});
		chk("irq full", 32'h1, {31'h0, irq});
		xf(1'b1, 8'h70, 32'h6);
		wt;
		chk("send allow", 32'h1, {31'h0, tx_send_enable});
		xf(1'b1, 8'h7c, 32'h1);
		wt;
		chk("irq clear", 32'h0, {31'h0, irq});
		@(posedge clk) status_fifo_full <= 1'b0;
		xf(1'b1, 8'h70, 32'h0000c006);
		#1;
		chk("status clear", 32'h1, {31'h0, tx_status_ptr_clear});
		chk("data clear", 32'h1, {31'h0, tx_data_ptr_clear});
		rd(8'h70, 32'h6, "flush self clear");
		chk("status clear end", 32'h0, {31'h0, tx_status_ptr_clear});
		chk("data clear end", 32'h0, {31'h0, tx_data_ptr_clear});
		$display("test 2 done");
		@(posedge clk) frame_active <= 1'b1;
		xf(1'b1, 8'h70, 32'h7);
		xf(1'b1, 8'h70, 32'h6);
		wt;
		rd(8'h70, 32'h7, "stop held");
		rd(8'h84, 32'h4, "state stopping");
		chk("send in frame", 32'h1, {31'h0, tx_send_enable});
		@(posedge clk) frame_active <= 1'b0;
		wt;
		rd(8'h70, 32'h4, "stopped");
		rd(8'h78, 32'h2, "irq stopped");
		rd(8'h84, 32'h1, "state off");
		chk("irq on", 32'h1, {31'h0, irq});
		$display("test 3 done");
		summarize;
	end
	// the tests need well under 1000 cycles
	initial
	begin
		#20000;
		num_errors = num_errors + 1;
		summarize;
	end
endmodule
bind tx_config_fifo_alloc tx_cfg_assertions tx_cfg_assertions_inst (.clk(clk), .rst_n(rst_n), .hsel(hsel),
	.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
	.hreadyout(hreadyout), .hresp(hresp), .frame_active(frame_active), .status_fifo_full(status_fifo_full),
	.tx_send_enable(tx_send_enable), .tx_status_ptr_clear(tx_status_ptr_clear),
	.tx_data_ptr_clear(tx_data_ptr_clear), .tx_status_bytes(tx_status_bytes), .tx_data_bytes(tx_data_bytes),
	.rx_bytes(rx_bytes), .must_be_one_bit(must_be_one_bit));

//--- testbench/tx_cfg_assertions.sv
/*
 checker for the transmit configuration register bank.
 assumes it is bound to the top module and sees only its ports.
*/
`timescale 1ns/10ps
module tx_cfg_assertions
(
	input wire clk,
	input wire rst_n,
	input wire hsel,
	input wire [31:0] haddr,
	input wire [1:0] htrans,
	input wire hwrite,
	input wire [31:0] hwdata,
	input wire hready,
	input wire [31:0] hrdata,
	input wire hreadyout,
	input wire hresp,
	input wire frame_active,
	input wire status_fifo_full,
	input wire tx_send_enable,
	input wire tx_status_ptr_clear,
	input wire tx_data_ptr_clear,
	input wire [14:0] tx_status_bytes,
	input wire [14:0] tx_data_bytes,
	input wire [14:0] rx_bytes,
	input wire must_be_one_bit
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);
	// address phase taken; hreadyout is tied high so no stall to track
	wire take = hsel && hready && htrans[1];
	a_stat_flush:
	assert property (take && hwrite && haddr[7:0] == 8'h70 ##1 hwdata[15] |=> tx_status_ptr_clear) else $error("no status clear");
	a_data_flush:
	assert property (take && hwrite && haddr[7:0] == 8'h70 ##1 hwdata[14] |=> tx_data_ptr_clear) else $error("no data clear");
	a_read_rsvd:
	assert property (take && !hwrite && haddr[7:0] == 8'h70 |=> hrdata[31:16] == 16'h0 && hrdata[13:3] == 11'h0)
		else $error("reserved bits not zero");
	a_mbo_copy:
	assert property (take && hwrite && haddr[7:0] == 8'h74 ##1 1'b1 |=> must_be_one_bit == $past(hwdata[20]))
		else $error("must be one copy wrong");
	a_fixed_status:
	assert property (tx_status_bytes == 15'h0200) else $error("status fifo not 512");
	a_total_split:
	assert property (tx_status_bytes + tx_data_bytes + rx_bytes == 15'h4000) else $error("split not 16KB");
	a_size_cap:
	assert property (tx_data_bytes <= 15'h3600 && rx_bytes >= 15'h0800) else $error("tx space above 14KB");
	a_frame_done:
	assert property ($fell(tx_send_enable) && !status_fifo_full && $past(rst_n) |-> !frame_active)
		else $error("stopped mid frame");
	a_zero_wait:
	assert property (hreadyout && !hresp) else $error("slave not ready or error");
endmodule
